// ### hdl/irw_pkg.sv
package irw_pkg;
  localparam int NPIN = 6;
  localparam int NPER = 8;
  localparam int NSRC = 14;
  localparam int PRI_W = 2;
  localparam int TICK_W = 24;

  // register byte addresses
  localparam logic [7:0] OFF_RST_CAUSE = 8'h00;
  localparam logic [7:0] OFF_NMI_CAUSE = 8'h04;
  localparam logic [7:0] OFF_STOP_WAKE = 8'h08;
  localparam logic [7:0] OFF_IDLE_WAKE = 8'h0c;
  localparam logic [7:0] OFF_EDGE_MODE = 8'h10;
  localparam logic [7:0] OFF_PIN_IN_EN = 8'h14;
  localparam logic [7:0] OFF_SET_PEND = 8'h18;
  localparam logic [7:0] OFF_CLR_PEND = 8'h1c;
  localparam logic [7:0] OFF_WAKE_STAT = 8'h20;
  localparam logic [7:0] OFF_WAKE_MASK = 8'h24;
  localparam logic [7:0] OFF_PRIORITY = 8'h28;
  localparam logic [7:0] OFF_CTRL = 8'h2c;
  localparam logic [7:0] OFF_TICK_LOAD = 8'h30;
  localparam logic [7:0] OFF_TICK_CNT = 8'h34;
  localparam logic [7:0] OFF_ACTIVE = 8'h38;

  // reset cause bits
  localparam int RC_PIN = 0;
  localparam int RC_POR = 1;
  localparam int RC_WDT = 2;
  localparam int RC_SW = 3;
  localparam int RC_LVD = 4;
  localparam int RC_W = 5;
  // nmi cause bits
  localparam int NC_WDT = 0;
  localparam int NC_LVD = 1;
  // control bits
  localparam int CTRL_SWRST = 0;
  localparam int CTRL_TICK_EN = 1;
  localparam int CTRL_TICK_FLAG = 16;

  // pin wake active condition, three bits a pin
  localparam int MODE_W = 3;
  localparam logic [2:0] MODE_RISE = 3'h0;
  localparam logic [2:0] MODE_FALL = 3'h1;
  localparam logic [2:0] MODE_LOW = 3'h2;
  localparam logic [2:0] MODE_HIGH = 3'h3;
  localparam logic [2:0] MODE_BOTH = 3'h4;

  // source numbering and vectors
  localparam logic [7:0] VEC_BASE = 8'h40;
  localparam int VEC_SHIFT = 2;
  localparam int SRC_UART_A_RX = 6;
  localparam int SRC_UART_B_TX = 9;
  localparam int SRC_SPI_ERR = 12;
  localparam logic [7:0] VEC_SPI_ERR = 8'h70;
endpackage : irw_pkg

// ### hdl/irw_top.sv
`timescale 1ns/1ps
module irw_top import irw_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  // reset and nmi requests
  input wire logic resetPin,
  input wire logic porReq,
  input wire logic wdtResetReq,
  input wire logic lvdResetReq,
  input wire logic wdtNmiReq,
  input wire logic lvdNmiReq,
  // interrupt sources
  input wire logic [NPIN-1:0] extPin,
  input wire logic [NPER-1:0] periphIrq,
  // cpu side
  output logic resetException,
  output logic nmiRequest,
  output logic tickException,
  output logic [NSRC-1:0] cpuIrq,
  output logic activeValid,
  output logic [3:0] activeNum,
  output logic [7:0] activeVector,
  output logic irqOut
);

  function automatic logic modeHit(input logic [2:0] m, input logic cur, input logic prev);
    unique case (m)
      MODE_RISE: modeHit = cur & ~prev;
      MODE_FALL: modeHit = ~cur & prev;
      MODE_LOW: modeHit = ~cur;
      MODE_HIGH: modeHit = cur;
      MODE_BOTH: modeHit = cur ^ prev;
      default: modeHit = 1'b0;
    endcase
  endfunction : modeHit

  function automatic logic [4:0] pick(input logic [NSRC-1:0] req,
                                      input logic [NSRC*PRI_W-1:0] pri);
    logic [PRI_W-1:0] best;
    logic found;
    pick = 5'h00;
    best = '1;
    found = 1'b0;
    for (int i = 0; i < NSRC; i++) begin
      if (req[i] && (!found || pri[i*PRI_W +: PRI_W] < best)) begin
        found = 1'b1;
        best = pri[i*PRI_W +: PRI_W];
        pick = {1'b1, 4'(i)};
      end
    end
  endfunction : pick

  logic [NPIN:0] pinMeta;
  logic [NPIN:0] pinSync;
  logic resetPinPrev;
  logic [RC_W-1:0] resetCause;
  logic [1:0] nmiCause;
  logic [NSRC-1:0] stopWake;
  logic [NSRC-1:0] idleWake;
  logic [NPIN*MODE_W-1:0] edgeMode;
  logic [NPIN-1:0] pinInEn;
  logic [NSRC-1:0] setPend;
  logic [NSRC-1:0] wakeStat;
  logic [NSRC-1:0] wakeMask;
  logic [NSRC*PRI_W-1:0] prioSel;
  logic [NSRC-1:0] srcPrev;
  logic swReq;
  logic tickEn;
  logic tickFlag;
  logic [TICK_W-1:0] tickReload;
  logic [TICK_W-1:0] tickCnt;
  logic [NPIN-1:0] pinEff;
  logic [NSRC-1:0] srcLevel;
  logic [NSRC-1:0] routeEn;
  logic [NSRC-1:0] wakeHit;
  logic [4:0] next_pick;
  logic resetPinRise;
  logic tickZero;
  logic wrCtrl;

  // two-flop synchroniser for the reset pin and the external pins
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pinMeta <= '0;
      pinSync <= '0;
    end else begin
      pinMeta <= {resetPin, extPin};
      pinSync <= pinMeta;
    end
  end

  // disabled input reads high; software should drive low before enabling
  always_comb begin
    for (int i = 0; i < NPIN; i++) begin
      pinEff[i] = pinInEn[i] ? pinSync[i] : 1'b1;
    end
  end

  assign srcLevel = {periphIrq, pinEff};
  // stop and idle enables are equivalent and ignore operating mode
  assign routeEn = stopWake | idleWake;
  assign resetPinRise = pinSync[NPIN] & ~resetPinPrev;
  assign wrCtrl = regWr && regAddr == OFF_CTRL;
  assign tickZero = tickEn && tickCnt == '0;

  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_wake
      if (g < NPIN) begin : g_pin
        assign wakeHit[g] = modeHit(edgeMode[g*MODE_W +: MODE_W], srcLevel[g],
                                    srcPrev[g]);
      end else begin : g_per
        assign wakeHit[g] = srcLevel[g] & ~srcPrev[g];
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      srcPrev <= '0;
      resetPinPrev <= 1'b0;
    end else begin
      srcPrev <= srcLevel;
      resetPinPrev <= pinSync[NPIN];
    end
  end

  // configuration registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stopWake <= '0;
      idleWake <= '0;
      edgeMode <= '0;
      pinInEn <= '0;
      wakeMask <= '0;
      prioSel <= '0;
      tickReload <= '0;
      tickEn <= 1'b0;
    end else if (regWr) begin
      unique case (regAddr)
        OFF_STOP_WAKE: stopWake <= regWrData[NSRC-1:0];
        OFF_IDLE_WAKE: idleWake <= regWrData[NSRC-1:0];
        OFF_EDGE_MODE: edgeMode <= regWrData[NPIN*MODE_W-1:0];
        OFF_PIN_IN_EN: pinInEn <= regWrData[NPIN-1:0];
        OFF_WAKE_MASK: wakeMask <= regWrData[NSRC-1:0];
        OFF_PRIORITY: prioSel <= regWrData[NSRC*PRI_W-1:0];
        OFF_TICK_LOAD: tickReload <= regWrData[TICK_W-1:0];
        OFF_CTRL: tickEn <= regWrData[CTRL_TICK_EN];
        default: ;
      endcase
    end
  end

  // reset requests and cause flags; a new cause wins over a clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      swReq <= 1'b0;
      resetException <= 1'b0;
      resetCause <= '0;
    end else begin
      swReq <= wrCtrl & regWrData[CTRL_SWRST];
      resetException <= resetPinRise | porReq | wdtResetReq | lvdResetReq | swReq;
      resetCause <= (resetCause & ~(regWr && regAddr == OFF_RST_CAUSE
                      ? regWrData[RC_W-1:0] : '0))
                    | {lvdResetReq, swReq, wdtResetReq, porReq, resetPinRise};
    end
  end

  // nmi cause flags; request stands while any cause is set
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      nmiCause <= '0;
      nmiRequest <= 1'b0;
    end else begin
      nmiCause <= (nmiCause & ~(regWr && regAddr == OFF_NMI_CAUSE
                    ? regWrData[1:0] : 2'h0)) | {lvdNmiReq, wdtNmiReq};
      nmiRequest <= |nmiCause;
    end
  end

  // tick counter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tickCnt <= '0;
      tickException <= 1'b0;
      tickFlag <= 1'b0;
    end else begin
      if (!tickEn) begin
        tickCnt <= tickReload;
      end else if (tickZero) begin
        tickCnt <= tickReload;
      end else begin
        tickCnt <= tickCnt - 1'b1;
      end
      tickException <= tickZero;
      if (tickZero) begin
        tickFlag <= 1'b1;
      end else if (regRd && regAddr == OFF_CTRL) begin
        tickFlag <= 1'b0;
      end
    end
  end

  // wake latch and forced pending; set wins over clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wakeStat <= '0;
      setPend <= '0;
    end else begin
      wakeStat <= (wakeStat & ~(regWr && regAddr == OFF_WAKE_STAT
                    ? regWrData[NSRC-1:0] : '0)) | (wakeHit & routeEn);
      setPend <= (setPend & ~(regWr && regAddr == OFF_CLR_PEND
                  ? regWrData[NSRC-1:0] : '0))
                 | (regWr && regAddr == OFF_SET_PEND ? regWrData[NSRC-1:0] : '0);
    end
  end

  assign next_pick = pick(cpuIrq, prioSel);

  // cpu request lines, active source and interrupt output
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpuIrq <= '0;
      activeValid <= 1'b0;
      activeNum <= '0;
      activeVector <= '0;
      irqOut <= 1'b0;
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        cpuIrq[i] <= (routeEn[i] ? wakeStat[i] : srcLevel[i]) | setPend[i];
      end
      activeValid <= next_pick[4];
      activeNum <= next_pick[3:0];
      activeVector <= VEC_BASE + {2'b00, next_pick[3:0], 2'b00};
      irqOut <= |(wakeStat & wakeMask);
    end
  end

  // read port, data in the cycle after the strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= '0;
    end else if (regRd) begin
      unique case (regAddr)
        OFF_RST_CAUSE: regRdData <= 32'(resetCause);
        OFF_NMI_CAUSE: regRdData <= 32'(nmiCause);
        OFF_STOP_WAKE: regRdData <= 32'(stopWake);
        OFF_IDLE_WAKE: regRdData <= 32'(idleWake);
        OFF_EDGE_MODE: regRdData <= 32'(edgeMode);
        OFF_PIN_IN_EN: regRdData <= 32'(pinInEn);
        OFF_SET_PEND: regRdData <= 32'(setPend);
        OFF_CLR_PEND: regRdData <= 32'(setPend);
        OFF_WAKE_STAT: regRdData <= 32'(wakeStat);
        OFF_WAKE_MASK: regRdData <= 32'(wakeMask);
        OFF_PRIORITY: regRdData <= 32'(prioSel);
        OFF_CTRL: regRdData <= 32'({tickFlag, 14'h0000, tickEn, 1'b0});
        OFF_TICK_LOAD: regRdData <= 32'(tickReload);
        OFF_TICK_CNT: regRdData <= 32'(tickCnt);
        OFF_ACTIVE: regRdData <= 32'({activeVector, 3'h0, activeValid, activeNum});
        default: regRdData <= '0;
      endcase
    end else begin
      regRdData <= '0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  chk_pin_reset: assert property (resetPinRise |=> resetException ##0 resetCause[RC_PIN])
    else $error("reset pin rise gave no reset exception");
  chk_reset_cause: assert property (wdtResetReq |=> resetCause[RC_WDT] && resetException)
    else $error("watchdog reset not recorded");
  chk_nmi_cause: assert property (lvdNmiReq |=> nmiCause[NC_LVD] ##1 nmiRequest)
    else $error("low-voltage nmi not raised");
  chk_tick_zero: assert property (tickZero |=> tickException && tickFlag
                                  && tickCnt == $past(tickReload))
    else $error("tick zero did not fire and reload");
  chk_prio_idle: assert property (cpuIrq == '0 |=> !activeValid)
    else $error("active source without request");
  chk_direct_route: assert property (!routeEn[SRC_UART_A_RX] && !setPend[SRC_UART_A_RX]
                                     |=> cpuIrq[SRC_UART_A_RX] == $past(periphIrq[0]))
    else $error("direct route not passed through");
  chk_input_force: assert property (!pinInEn[0] && !routeEn[0] |=> cpuIrq[0])
    else $error("disabled pin input not high");
  chk_wake_hold: assert property (wakeStat[1] && !(regWr && regAddr == OFF_WAKE_STAT)
                                  |=> wakeStat[1])
    else $error("wake request lost before clear");
  chk_set_pend: assert property (regWr && regAddr == OFF_SET_PEND && regWrData[SRC_UART_B_TX]
                                 |=> ##1 cpuIrq[SRC_UART_B_TX])
    else $error("forced pending not delivered");
  chk_wake_level: assert property (wakeStat[2] && routeEn[2] |=> cpuIrq[2])
    else $error("wake request not a high level");
  chk_vector_map: assert property (activeValid |-> activeVector
                                   == VEC_BASE + {2'b00, activeNum, 2'b00})
    else $error("vector offset wrong");
  chk_irq_out: assert property (|(wakeStat & wakeMask) |=> irqOut)
    else $error("unmasked wake status did not raise irq");
  chk_irq_quiet: assert property (!(|(wakeStat & wakeMask)) |=> !irqOut)
    else $error("irq raised without unmasked wake status");
  chk_route_off: assert property (!routeEn[0] && !wakeStat[0] |=> !wakeStat[0])
    else $error("wake latched with route disabled");
  chk_route_on: assert property (wakeHit[0] && routeEn[0] |=> wakeStat[0])
    else $error("routed wake hit not latched");
  chk_idle_route: assert property (idleWake[3] && wakeHit[3] |=> wakeStat[3])
    else $error("idle route enable not honoured");
  chk_wake_path: assert property (routeEn[8] && wakeStat[8] |=> cpuIrq[8])
    else $error("peripheral wake request not delivered");
  chk_rise_mode: assert property (edgeMode[2:0] == MODE_RISE && routeEn[0] && pinEff[0]
                                  && !srcPrev[0] |=> wakeStat[0])
    else $error("rising edge wake missed");
  chk_low_mode: assert property (edgeMode[2:0] == MODE_LOW && routeEn[0] && !pinEff[0]
                                 |=> wakeStat[0])
    else $error("low level wake missed");
  chk_never_mode: assert property (edgeMode[2:0] > MODE_BOTH |-> !wakeHit[0])
    else $error("unused wake condition fired");
  chk_sw_reset: assert property (wrCtrl && regWrData[CTRL_SWRST]
                                 |=> ##1 resetException && resetCause[RC_SW])
    else $error("software reset request not taken");
  chk_nmi_wdt: assert property (wdtNmiReq |=> nmiCause[NC_WDT] ##1 nmiRequest)
    else $error("watchdog nmi not raised");
  chk_tick_count: assert property (tickEn && tickCnt != '0
                                   |=> tickCnt == $past(tickCnt) - 1'b1)
    else $error("tick counter did not count down");
  chk_tick_load: assert property (!tickEn |=> tickCnt == $past(tickReload))
    else $error("idle tick counter not loaded");
  chk_spi_vector: assert property (activeValid && activeNum == 4'(SRC_SPI_ERR)
                                   |-> activeVector == VEC_SPI_ERR)
    else $error("spi error vector wrong");
  chk_active_req: assert property (activeValid |-> $past(cpuIrq) != '0)
    else $error("active source shown without request");

  cov_pin_wake: cover property (wakeHit[0] && routeEn[0] ##1 wakeStat[0] ##1 cpuIrq[0]);
  cov_spi_err: cover property (activeValid && activeVector == VEC_SPI_ERR);
  cov_tick: cover property (tickException);
  cov_reset_pin: cover property (resetPinRise ##1 resetException);
  cov_set_pend: cover property (setPend[SRC_UART_B_TX] ##1 cpuIrq[SRC_UART_B_TX]);

endmodule : irw_top

// ### verification/irw_periph_model.sv
`timescale 1ns/1ps
module irw_periph_model (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // bench commands
  input wire logic [7:0] raise,
  input wire logic [7:0] ack,
  input wire logic slow,
  // requests to the device
  output logic [7:0] periphIrq
);
  logic [7:0] lag1;
  logic [7:0] lag2;
  // slow sources assert three cycles after the command, two cycles after fast ones
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lag1 <= 8'h00;
      lag2 <= 8'h00;
    end else begin
      lag1 <= raise;
      lag2 <= lag1;
    end
  end
  // request level stands until the handler acknowledges it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) periphIrq <= 8'h00;
    else periphIrq <= (periphIrq | (slow ? lag2 : raise)) & ~ack;
  end
endmodule : irw_periph_model

// ### verification/tb_top.sv
`timescale 1ns/1ps
module tb_top import irw_pkg::*;;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0, regRd = 1'b0;
  logic [31:0] regRdData;
  logic resetPin = 1'b0, porReq = 1'b0, wdtResetReq = 1'b0, lvdResetReq = 1'b0;
  logic wdtNmiReq = 1'b0, lvdNmiReq = 1'b0;
  logic [5:0] extPin = 6'h00;
  logic [7:0] periphIrq, raise = 8'h00, ack = 8'h00;
  logic slow = 1'b0;
  logic resetException, nmiRequest, tickException, activeValid, irqOut;
  logic [13:0] cpuIrq;
  logic [3:0] activeNum;
  logic [7:0] activeVector;
  logic [4:0] s0 = 5'h06;
  int failures = 0, checked = 0, rstCnt = 0, n;

  irw_top DUT (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .resetPin(resetPin),
    .porReq(porReq), .wdtResetReq(wdtResetReq), .lvdResetReq(lvdResetReq),
    .wdtNmiReq(wdtNmiReq), .lvdNmiReq(lvdNmiReq), .extPin(extPin), .periphIrq(periphIrq),
    .resetException(resetException), .nmiRequest(nmiRequest),
    .tickException(tickException), .cpuIrq(cpuIrq), .activeValid(activeValid),
    .activeNum(activeNum), .activeVector(activeVector), .irqOut(irqOut));
  irw_periph_model src (.clk(clk), .sys_rst(sys_rst), .raise(raise), .ack(ack),
    .slow(slow), .periphIrq(periphIrq));

  always #25 clk = ~clk;
  always @(posedge clk) if (resetException === 1'b1) rstCnt++;

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rdc(input string name, input logic [7:0] a, input logic [31:0] exp,
                     input logic [31:0] msk = 32'hffffffff);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    chk(name, exp, regRdData & msk);
  endtask : rdc
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask : cyc
  task automatic srcPulse(input logic [7:0] r, input logic [7:0] a, input logic s);
    @(posedge clk);
    raise <= r;
    ack <= a;
    slow <= s;
    @(posedge clk);
    raise <= 8'h00;
    ack <= 8'h00;
  endtask : srcPulse
  task automatic end_sim;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  initial begin
    #250000;
    failures++;
    end_sim();
  end

  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rdc("rstCause", OFF_RST_CAUSE, 32'h0);
    rdc("unmapped", 8'hfc, 32'h0);
    chk("pinsOff", 6'h3f, cpuIrq[5:0]);
    wr(OFF_PIN_IN_EN, 32'h3f);
    cyc(4);
    chk("pinsOn", 6'h00, cpuIrq[5:0]);
    @(posedge clk);
    resetPin <= 1'b1;
    cyc(6);
    chk("pinEvents", 1, rstCnt);
    rdc("causePin", OFF_RST_CAUSE, 32'h1);
    @(posedge clk);
    porReq <= 1'b1;
    wdtResetReq <= 1'b1;
    lvdResetReq <= 1'b1;
    @(posedge clk);
    porReq <= 1'b0;
    wdtResetReq <= 1'b0;
    lvdResetReq <= 1'b0;
    resetPin <= 1'b0;
    wr(OFF_CTRL, 32'h1);
    cyc(4);
    rdc("causeAll", OFF_RST_CAUSE, 32'h1f);
    chk("rstEvents", 3, rstCnt);
    wr(OFF_RST_CAUSE, 32'h1f);
    rdc("causeClr", OFF_RST_CAUSE, 32'h0);
    @(posedge clk);
    wdtNmiReq <= 1'b1;
    lvdNmiReq <= 1'b1;
    @(posedge clk);
    wdtNmiReq <= 1'b0;
    lvdNmiReq <= 1'b0;
    cyc(3);
    chk("nmiOut", 1, nmiRequest);
    rdc("nmiCause", OFF_NMI_CAUSE, 32'h3);
    wr(OFF_NMI_CAUSE, 32'h3);
    cyc(3);
    chk("nmiIdle", 0, nmiRequest);
    // each peripheral alone, fast and slow sources alternating
    for (int k = 0; k < NPER; k++) begin
      srcPulse(8'h01 << k, 8'h00, k[0]);
      cyc(6);
      chk("perIrq", 1, cpuIrq[6+k]);
      chk("actNum", 6 + k, activeNum);
      chk("actVec", VEC_BASE + 4 * (6 + k), activeVector);
      srcPulse(8'h00, 8'h01 << k, 1'b0);
      cyc(3);
      chk("perOff", 0, cpuIrq[6+k]);
    end
    wr(OFF_PRIORITY, 32'h1000);
    srcPulse(8'h81, 8'h00, 1'b0);
    cyc(5);
    chk("prioNum", 13, activeNum);
    chk("prioVal", 1, activeValid);
    srcPulse(8'h00, 8'h81, 1'b0);
    wr(OFF_PRIORITY, 32'h0);
    wr(OFF_WAKE_MASK, 32'h1);
    // even modes routed by stop control, odd ones by idle control
    for (int m = 0; m < 5; m++) begin
      @(posedge clk);
      extPin[0] <= s0[m];
      wr(OFF_EDGE_MODE, m);
      wr(OFF_STOP_WAKE, {31'h0, ~m[0]});
      wr(OFF_IDLE_WAKE, {31'h0, m[0]});
      cyc(4);
      wr(OFF_WAKE_STAT, 32'h1);
      cyc(4);
      rdc("wakeQuiet", OFF_WAKE_STAT, 32'h0);
      @(posedge clk);
      extPin[0] <= ~s0[m];
      cyc(6);
      rdc("wakeHit", OFF_WAKE_STAT, 32'h1);
      chk("wakeIrq", 1, cpuIrq[0]);
      chk("wakeOut", 1, irqOut);
    end
    wr(OFF_EDGE_MODE, 32'h7);
    wr(OFF_WAKE_STAT, 32'h1);
    cyc(4);
    chk("wakeNever", 0, cpuIrq[0]);
    chk("outOff", 0, irqOut);
    wr(OFF_STOP_WAKE, 32'h0);
    wr(OFF_IDLE_WAKE, 32'h0);
    cyc(4);
    chk("direct", 1, cpuIrq[0]);
    wr(OFF_SET_PEND, 32'h200);
    cyc(3);
    chk("pendIrq", 1, cpuIrq[9]);
    rdc("pendRd", OFF_SET_PEND, 32'h200);
    wr(OFF_CLR_PEND, 32'h200);
    cyc(3);
    chk("pendClr", 0, cpuIrq[9]);
    wr(OFF_TICK_LOAD, 32'h3);
    wr(OFF_CTRL, 32'h2);
    n = 0;
    while (tickException !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tickException !== 1'b1 && n < 40);
    chk("tickGap", 4, n);
    rdc("tickFlag", OFF_CTRL, 32'h10002, 32'h10002);
    wr(OFF_CTRL, 32'h0);
    end_sim();
  end
endmodule : tb_top
